// *** inc/pevh_cfg.svh ***
// timing and geometry constants of the print engine video handshake
`ifndef PEVH_CFG_SVH
`define PEVH_CFG_SVH

`define PEVH_CLK_PERIOD_NS   10
`define PEVH_WAIT_TIME_NS    1000000
`define PEVH_WAIT_CYCLES     (`PEVH_WAIT_TIME_NS / `PEVH_CLK_PERIOD_NS)
`define PEVH_TOP_MAX_NS      100
`define PEVH_TOP_MAX_CYCLES  (`PEVH_TOP_MAX_NS / `PEVH_CLK_PERIOD_NS)
`define PEVH_TOP_WIDTH_NS    200
`define PEVH_TOP_WIDTH_CYC   ((`PEVH_TOP_WIDTH_NS + `PEVH_CLK_PERIOD_NS - 1) / `PEVH_CLK_PERIOD_NS)
`define PEVH_LINE_SYNC_N_WIDTH_NS  80
`define PEVH_LINE_SYNC_N_WIDTH_CYC ((`PEVH_LINE_SYNC_N_WIDTH_NS + `PEVH_CLK_PERIOD_NS - 1) / `PEVH_CLK_PERIOD_NS)
`define PEVH_PIX_DIV         4
`define PEVH_PIXELS_PER_LINE 64
`define PEVH_LINES_PER_PLANE 32
`define PEVH_FIFO_DEPTH      4
`define PEVH_PIX_WIDTH       8
`define PEVH_PLANE_LAST_CLR  2'h3
`define PEVH_PLANE_LAST_MONO 2'h0

`endif

// *** inc/pevh_pkg.sv ***
// types shared by the print engine video handshake design
package pevh_pkg;

    typedef enum logic [2:0] {
        PEVH_ST_WAIT,
        PEVH_ST_IDLE,
        PEVH_ST_INIT_ROT,
        PEVH_ST_TOP,
        PEVH_ST_LINES,
        PEVH_ST_LAST_ROT
    } pevh_state_t;

    // handshake lines toward the rendering controller, all active low
    typedef struct packed {
        logic engine_ready_n;
        logic vsync_n;
        logic line_sync_n;
    } pevh_hs_t;

    // lines toward the mechanical controller
    typedef struct packed {
        logic print_seq_cmd;
        logic initial_rotation;
        logic last_rotation;
    } pevh_mech_t;

endpackage

// *** design/pevh_fifo.sv ***
// small synchronous fifo for pixel words between video capture and modulator
`timescale 1ns/100ps
module pevh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
        wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        wr_next    = push ? wrap_inc(wr_reg) : wr_reg;
        rd_next    = pop ? wrap_inc(rd_reg) : rd_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            count_reg <= '0;
        end else begin
            wr_reg    <= wr_next;
            rd_reg    <= rd_next;
            count_reg <= count_next;
        end
    end

    // storage needs no reset; valid data is tracked by count_reg
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    // a write may never land on the head word while the reader is held off
    a_fifo_hold_head : assert property (@(posedge clk_i) disable iff (!rst_b_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("fifo head word changed while held");
endmodule

// *** design/pevh_top.sv ***
// engine-side video handshake: ready, print request, vertical/line sync, pixel path
// =============================================================================
`timescale 1ns/100ps
`include "pevh_cfg.svh"
module pevh_top import pevh_pkg::*; #(
    parameter int WAIT_CYCLES     = `PEVH_WAIT_CYCLES,
    parameter int PIX_DIV         = `PEVH_PIX_DIV,
    parameter int PIXELS_PER_LINE = `PEVH_PIXELS_PER_LINE,
    parameter int LINES_PER_PLANE = `PEVH_LINES_PER_PLANE,
    parameter int FIFO_DEPTH      = `PEVH_FIFO_DEPTH
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       print_request_n_i,
    input  wire logic                       mono_mode_i,
    input  wire logic                       rotation_done_i,
    input  wire logic [`PEVH_PIX_WIDTH-1:0] video_in_i,
    input  wire logic                       pixel_ready_i,
    output pevh_hs_t                        handshake_o,
    output pevh_mech_t                      mech_o,
    output logic      [`PEVH_PIX_WIDTH-1:0] pixel_out_o,
    output logic                            pixel_valid_o,
    output logic      [1:0]                 plane_o,
    output logic                            idle_state_o
);
    localparam int PW        = `PEVH_PIX_WIDTH;
    localparam int SW        = PW + 3;
    localparam int TOP_MAX   = `PEVH_TOP_MAX_CYCLES;
    localparam int TOP_WIDTH = `PEVH_TOP_WIDTH_CYC;
    localparam int LS_WIDTH  = `PEVH_LINE_SYNC_N_WIDTH_CYC;

    // =========================================================================
    // reset release and input synchronisers
    logic          rst_meta_reg;
    logic          rst_b;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic          done_d_reg;
    logic          print_request_n_n_s;
    logic          mono_s;
    logic          done_rise;
    logic [PW-1:0] video_s;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_reg <= 1'b0;
            rst_b        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_b        <= rst_meta_reg;
        end
    end

    // request idles high so nothing starts before the line is seen
    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg  <= {1'b1, {(SW-1){1'b0}}};
            sync2_reg  <= {1'b1, {(SW-1){1'b0}}};
            done_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {print_request_n_i, mono_mode_i, rotation_done_i, video_in_i};
            sync2_reg  <= sync1_reg;
            done_d_reg <= sync2_reg[PW];
        end
    end

    assign print_request_n_n_s  = sync2_reg[PW+2];
    assign mono_s    = sync2_reg[PW+1];
    assign done_rise = sync2_reg[PW] & ~done_d_reg;
    assign video_s   = sync2_reg[PW-1:0];

    // =========================================================================
    // page sequencer
    pevh_state_t state_reg;
    pevh_state_t state_next;
    pevh_hs_t    hs_reg;
    pevh_hs_t    hs_next;
    pevh_mech_t  mech_reg;
    pevh_mech_t  mech_next;
    logic [16:0] cnt_reg;
    logic [16:0] cnt_next;
    logic [15:0] line_reg;
    logic [15:0] line_next;
    logic [15:0] pix_reg;
    logic [15:0] pix_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic [1:0]  plane_reg;
    logic [1:0]  plane_next;
    logic [1:0]  last_plane_reg;
    logic [1:0]  last_plane_next;
    logic        seen_reg;
    logic        seen_next;
    logic        idle_reg;
    logic        idle_next;
    logic        fifo_in_ready;
    logic        push;
    logic        page_end;

    always_comb begin
        state_next      = state_reg;
        hs_next         = hs_reg;
        mech_next       = mech_reg;
        cnt_next        = cnt_reg;
        line_next       = line_reg;
        pix_next        = pix_reg;
        div_next        = div_reg;
        plane_next      = plane_reg;
        last_plane_next = last_plane_reg;
        seen_next       = seen_reg;
        idle_next       = idle_reg;
        push            = 1'b0;
        page_end        = 1'b0;
        mech_next.print_seq_cmd = 1'b0;
        case (state_reg)
            PEVH_ST_WAIT: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == 17'(WAIT_CYCLES - 1)) begin
                    state_next             = PEVH_ST_IDLE;
                    hs_next.engine_ready_n = 1'b0;
                    idle_next              = 1'b1;
                end
            end
            PEVH_ST_IDLE: begin
                if (!print_request_n_n_s) begin
                    state_next                 = PEVH_ST_INIT_ROT;
                    mech_next.print_seq_cmd    = 1'b1;
                    mech_next.initial_rotation = 1'b1;
                    idle_next                  = 1'b0;
                    plane_next                 = 2'h0;
                    last_plane_next = mono_s ? `PEVH_PLANE_LAST_MONO : `PEVH_PLANE_LAST_CLR;
                end
            end
            PEVH_ST_INIT_ROT: begin
                if (done_rise) begin
                    state_next                 = PEVH_ST_TOP;
                    mech_next.initial_rotation = 1'b0;
                    hs_next.vsync_n            = 1'b0;
                    cnt_next                   = '0;
                    seen_next                  = 1'b0;
                end
            end
            PEVH_ST_TOP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == 17'(TOP_WIDTH - 1)) begin
                    state_next          = PEVH_ST_LINES;
                    hs_next.vsync_n     = 1'b1;
                    hs_next.line_sync_n = 1'b0;
                    cnt_next            = '0;
                    line_next           = '0;
                    pix_next            = '0;
                    div_next            = '0;
                end
            end
            PEVH_ST_LINES: begin
                if (!hs_reg.line_sync_n) begin
                    cnt_next = cnt_reg + 1'b1;
                    if (cnt_reg == 17'(LS_WIDTH - 1)) begin
                        hs_next.line_sync_n = 1'b1;
                    end
                end else if (div_reg != 8'(PIX_DIV - 1)) begin
                    div_next = div_reg + 1'b1;
                end else if (fifo_in_ready) begin
                    // a full fifo holds the pixel tick, stalling the line timing
                    push     = 1'b1;
                    div_next = '0;
                    pix_next = pix_reg + 1'b1;
                    if (pix_reg == 16'(PIXELS_PER_LINE - 1)) begin
                        pix_next = '0;
                        cnt_next = '0;
                        if (line_reg != 16'(LINES_PER_PLANE - 1)) begin
                            line_next           = line_reg + 1'b1;
                            hs_next.line_sync_n = 1'b0;
                        end else if (plane_reg != last_plane_reg) begin
                            plane_next      = plane_reg + 1'b1;
                            state_next      = PEVH_ST_TOP;
                            hs_next.vsync_n = 1'b0;
                        end else begin
                            page_end = 1'b1;
                            if (seen_reg || !print_request_n_n_s) begin
                                state_next              = PEVH_ST_TOP;
                                hs_next.vsync_n         = 1'b0;
                                mech_next.print_seq_cmd = 1'b1;
                                plane_next              = 2'h0;
                                seen_next               = 1'b0;
                            end else begin
                                state_next              = PEVH_ST_LAST_ROT;
                                mech_next.last_rotation = 1'b1;
                            end
                        end
                    end
                end
            end
            PEVH_ST_LAST_ROT: begin
                if (done_rise) begin
                    state_next              = PEVH_ST_IDLE;
                    mech_next.last_rotation = 1'b0;
                    idle_next               = 1'b1;
                end
            end
            default: begin
                state_next = PEVH_ST_WAIT;
            end
        endcase
        // a request seen while a page runs wins over the page-start clear
        if ((state_reg == PEVH_ST_TOP || state_reg == PEVH_ST_LINES) && !print_request_n_n_s) begin
            seen_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            state_reg      <= PEVH_ST_WAIT;
            hs_reg         <= '1;
            mech_reg       <= '0;
            cnt_reg        <= '0;
            line_reg       <= '0;
            pix_reg        <= '0;
            div_reg        <= '0;
            plane_reg      <= 2'h0;
            last_plane_reg <= `PEVH_PLANE_LAST_CLR;
            seen_reg       <= 1'b0;
            idle_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            hs_reg         <= hs_next;
            mech_reg       <= mech_next;
            cnt_reg        <= cnt_next;
            line_reg       <= line_next;
            pix_reg        <= pix_next;
            div_reg        <= div_next;
            plane_reg      <= plane_next;
            last_plane_reg <= last_plane_next;
            seen_reg       <= seen_next;
            idle_reg       <= idle_next;
        end
    end

    // =========================================================================
    // pixel buffer and registered output stage toward the modulator
    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [PW-1:0] fifo_out_data;
    logic [PW-1:0] pix_out_reg;
    logic [PW-1:0] pix_out_next;
    logic          pix_valid_reg;
    logic          pix_valid_next;

    pevh_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (mclk_i),
        .rst_b_i     (rst_b),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (video_s),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    assign fifo_out_ready = !pix_valid_reg || pixel_ready_i;

    always_comb begin
        pix_out_next   = pix_out_reg;
        pix_valid_next = pix_valid_reg;
        if (fifo_out_ready) begin
            pix_valid_next = fifo_out_valid;
            if (fifo_out_valid) begin
                pix_out_next = fifo_out_data;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b) begin
        if (!rst_b) begin
            pix_out_reg   <= '0;
            pix_valid_reg <= 1'b0;
        end else begin
            pix_out_reg   <= pix_out_next;
            pix_valid_reg <= pix_valid_next;
        end
    end

    assign handshake_o   = hs_reg;
    assign mech_o        = mech_reg;
    assign pixel_out_o   = pix_out_reg;
    assign pixel_valid_o = pix_valid_reg;
    assign plane_o       = plane_reg;
    assign idle_state_o  = idle_reg;

    // =========================================================================
    // checks
    a_ready_after_wait : assert property (@(posedge mclk_i) disable iff (!rst_b)
        $fell(handshake_o.engine_ready_n) |-> $past(state_reg) == PEVH_ST_WAIT && idle_state_o)
        else $error("engine ready asserted outside the wait exit");
    a_request_starts : assert property (@(posedge mclk_i) disable iff (!rst_b)
        state_reg == PEVH_ST_IDLE && !print_request_n_n_s |=> mech_o.print_seq_cmd
            && mech_o.initial_rotation ##1 !mech_o.print_seq_cmd)
        else $error("print request did not start the print sequence");
    a_vsync_bound : assert property (@(posedge mclk_i) disable iff (!rst_b)
        state_reg == PEVH_ST_INIT_ROT && done_rise |-> ##[1:TOP_MAX] !handshake_o.vsync_n)
        else $error("vertical sync late after initial rotation");
    a_vsync_width : assert property (@(posedge mclk_i) disable iff (!rst_b)
        $fell(handshake_o.vsync_n) |-> !handshake_o.vsync_n [*8])
        else $error("vertical sync pulse too short");
    a_pixel_hold : assert property (@(posedge mclk_i) disable iff (!rst_b)
        pixel_valid_o && !pixel_ready_i |=> pixel_valid_o && $stable(pixel_out_o))
        else $error("pixel word dropped under back-pressure");
    a_request_seen : assert property (@(posedge mclk_i) disable iff (!rst_b)
        state_reg == PEVH_ST_LINES && !print_request_n_n_s |=> seen_reg)
        else $error("request during page not remembered");
    a_wind_down : assert property (@(posedge mclk_i) disable iff (!rst_b)
        page_end && !seen_reg && print_request_n_n_s |=> mech_o.last_rotation && handshake_o.vsync_n)
        else $error("page end without request did not start last rotation");
    a_standby_entry : assert property (@(posedge mclk_i) disable iff (!rst_b)
        state_reg == PEVH_ST_LAST_ROT && done_rise |=> idle_state_o && !mech_o.last_rotation)
        else $error("standby not entered after last rotation");
    a_continue_page : assert property (@(posedge mclk_i) disable iff (!rst_b)
        page_end && (seen_reg || !print_request_n_n_s) |=> !mech_o.last_rotation && !handshake_o.vsync_n
            && mech_o.print_seq_cmd)
        else $error("next page did not continue the sequence");
endmodule

// *** sim/pevh_render_model.sv ***
// rendering controller model: page requests and line-aligned video
`timescale 1ns/100ps
module pevh_render_model import pevh_pkg::*; (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire pevh_hs_t   hs_i,
    input  wire logic       mono_i,
    input  wire logic       load_i,
    input  wire logic [3:0] pages_i,
    output logic            print_request_n_o,
    output logic [7:0]      video_o
);
    logic [3:0] pages_left;
    logic [3:0] line_cnt;
    logic [2:0] hold_cnt;
    logic [1:0] vs_cnt;
    logic [1:0] plane;
    logic       want;
    logic       page_bit;
    pevh_hs_t   hs_q;
    wire        vs_fall    = hs_q.vsync_n && !hs_i.vsync_n;
    wire        ls_fall    = hs_q.line_sync_n && !hs_i.line_sync_n;
    wire        page_start = vs_fall && (mono_i || vs_cnt == 2'h0);

    // ==========
    // request and video
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {pages_left, line_cnt, hold_cnt, vs_cnt, plane, want, page_bit} <= '0;
            hs_q              <= 3'h7;
            print_request_n_o <= 1'b1;
            video_o           <= 8'h00;
        end else begin
            hs_q              <= hs_i;
            // short pulse per page, so one request never counts for two pages
            print_request_n_o <= (hold_cnt == 3'h0);
            if (hold_cnt != 3'h0) begin
                hold_cnt <= hold_cnt - 3'h1;
            end else if (want && !hs_i.engine_ready_n) begin
                hold_cnt   <= 3'h6;
                want       <= 1'b0;
                pages_left <= pages_left - 4'h1;
            end
            if (load_i) begin
                pages_left <= pages_i;
                want       <= 1'b1;
            end else if (page_start && pages_left != 4'h0) begin
                want <= 1'b1; // next page asked for while this one prints
            end
            if (vs_fall) begin
                plane    <= mono_i ? 2'h0 : vs_cnt;
                vs_cnt   <= mono_i ? 2'h0 : vs_cnt + 2'h1;
                page_bit <= page_bit ^ page_start;
                line_cnt <= 4'h0;
            end
            if (ls_fall) begin
                // one value per line, held through any stalled pixel ticks
                video_o  <= {page_bit, plane, 1'b1, line_cnt};
                line_cnt <= line_cnt + 4'h1;
            end else if (!hs_i.vsync_n) begin
                video_o <= ~video_o; // no line yet: nothing stable
            end
        end
    end
endmodule

// *** sim/pevh_bench.sv ***
// self-checking bench for the print engine video handshake
`timescale 1ns/100ps
`include "pevh_cfg.svh"
`define PEVH_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t got %0h expected %0h", $time, (got), (exp)); end end
module pevh_bench import pevh_pkg::*;;
    localparam int WAIT = 20;
    localparam int PPL  = 4;
    localparam int LPP  = 2;
    logic       mclk_i, rst_b_i, mono_mode_i, pixel_ready_i, load_b, stall;
    logic       print_request_n_i, pixel_valid_o, idle_state_o;
    logic       rotation_done_i = 1'b0;
    logic       pv_hold = 1'b0;
    logic       top_pend = 1'b0;
    logic       vs_prev = 1'b1;
    logic       ls_prev = 1'b1;
    logic [3:0] pages_b, stall_cnt;
    logic [7:0] video_in_i, pixel_out_o, pv_data;
    logic [1:0] plane_o;
    logic [7:0] got_q[$];
    logic [1:0] pl_q[$];
    pevh_hs_t   handshake_o;
    pevh_mech_t mech_o;
    int         fails, cmp_count, cmd_pulses, last_rots, rot_cnt, top_cnt, page_no, ls_falls;

    pevh_top #(.WAIT_CYCLES(WAIT), .PIXELS_PER_LINE(PPL), .LINES_PER_PLANE(LPP)) dut_u (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .print_request_n_i(print_request_n_i),
        .mono_mode_i(mono_mode_i), .rotation_done_i(rotation_done_i),
        .video_in_i(video_in_i), .pixel_ready_i(pixel_ready_i), .handshake_o(handshake_o),
        .mech_o(mech_o), .pixel_out_o(pixel_out_o), .pixel_valid_o(pixel_valid_o),
        .plane_o(plane_o), .idle_state_o(idle_state_o));
    pevh_render_model model_u (
        .clk_i(mclk_i), .rst_b_i(rst_b_i), .hs_i(handshake_o), .mono_i(mono_mode_i),
        .load_i(load_b), .pages_i(pages_b), .print_request_n_o(print_request_n_i),
        .video_o(video_in_i));

    // ==========
    // mechanics, modulator and watchers
    always @(posedge mclk_i) begin
        if (pv_hold) `PEVH_CHK({pixel_valid_o, pixel_out_o}, {1'b1, pv_data})
        pv_hold = (pixel_valid_o === 1'b1) && !pixel_ready_i;
        pv_data = pixel_out_o;
        if (pixel_valid_o === 1'b1 && pixel_ready_i) got_q.push_back(pixel_out_o);
        // plane index is taken at each frame start; it runs ahead of buffered pixels
        if (vs_prev === 1'b1 && handshake_o.vsync_n === 1'b0) pl_q.push_back(plane_o);
        if (ls_prev === 1'b1 && handshake_o.line_sync_n === 1'b0) ls_falls++;
        vs_prev = handshake_o.vsync_n;
        ls_prev = handshake_o.line_sync_n;
        if (mech_o.print_seq_cmd === 1'b1) cmd_pulses++;
        rot_cnt = (mech_o.initial_rotation === 1'b1 || mech_o.last_rotation === 1'b1) ?
                  rot_cnt + 1 : 0;
        if (rot_cnt == 1 && mech_o.last_rotation === 1'b1) last_rots++;
        top_cnt++;
        if (rot_cnt == 7 && mech_o.initial_rotation === 1'b1) begin
            top_pend = 1'b1;
            top_cnt  = 0;
        end
        if (top_pend && handshake_o.vsync_n === 1'b0) begin
            `PEVH_CHK(top_cnt <= `PEVH_TOP_MAX_CYCLES, 1'b1)
            top_pend = 1'b0;
        end
        rotation_done_i <= (rot_cnt >= 7);
        stall_cnt       <= stall_cnt + 4'h1;
        // ready 2 of 16 cycles: slower than the pixel ticks, so the fifo fills
        pixel_ready_i   <= !stall || stall_cnt[3:1] == 3'h7;
    end

    // ==========
    // tests
    task automatic test_power_up;
        int n;
        n = 0;
        do begin @(negedge mclk_i); n++; end while (handshake_o.engine_ready_n !== 1'b0 && n < 200);
        `PEVH_CHK(n >= WAIT && n <= WAIT + 5, 1'b1)
        `PEVH_CHK(idle_state_o, 1'b1)
        $display("test power up done");
    endtask

    task automatic run_job(input logic mono, input int pages, input logic stl, input string name);
        int n, k, j;
        logic [7:0] exp;
        got_q.delete();
        pl_q.delete();
        cmd_pulses = 0;
        last_rots  = 0;
        ls_falls   = 0;
        k          = 0;
        j          = 0;
        @(posedge mclk_i);
        mono_mode_i <= mono;
        stall       <= stl;
        pages_b     <= pages[3:0];
        load_b      <= 1'b1;
        @(posedge mclk_i);
        load_b <= 1'b0;
        n = 0;
        do begin @(negedge mclk_i); n++; end while (mech_o.print_seq_cmd !== 1'b1 && n < 20);
        `PEVH_CHK(n <= 8, 1'b1)
        @(negedge mclk_i);
        `PEVH_CHK({mech_o.print_seq_cmd, mech_o.initial_rotation, idle_state_o}, 3'b010)
        n = 0;
        // stalls keep words queued past standby, so wait for the drained output too
        while (!(last_rots > 0 && idle_state_o === 1'b1 && pixel_valid_o === 1'b0)
               && n < 5000) begin
            @(negedge mclk_i);
            n++;
        end
        `PEVH_CHK(n < 5000, 1'b1)
        `PEVH_CHK(last_rots, 1)
        `PEVH_CHK(cmd_pulses, pages)
        `PEVH_CHK(idle_state_o, 1'b1)
        `PEVH_CHK(got_q.size(), pages * (mono ? 1 : 4) * LPP * PPL)
        `PEVH_CHK(pl_q.size(), pages * (mono ? 1 : 4))
        `PEVH_CHK(ls_falls, pages * (mono ? 1 : 4) * LPP)
        for (int p = 0; p < pages; p++) begin
            page_no++;
            for (int c = 0; c < (mono ? 1 : 4); c++) begin
                if (j < pl_q.size()) `PEVH_CHK(pl_q[j], c[1:0])
                j++;
                for (int l = 0; l < LPP; l++)
                    for (int x = 0; x < PPL; x++) begin
                        exp = {page_no[0], c[1:0], 1'b1, l[3:0]};
                        if (k < got_q.size()) `PEVH_CHK(got_q[k], exp)
                        k++;
                    end
            end
        end
        $display("test %s done", name);
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    initial begin
        #200000; // run needs under 1500 cycles; this allows 20000, over ten times that
        fails++;
        report_and_stop();
    end

    initial begin
        {rst_b_i, mono_mode_i, pixel_ready_i, load_b, stall} = 5'h00;
        pages_b   = 4'h0;
        stall_cnt = 4'h0;
        repeat (10) @(posedge mclk_i);
        `PEVH_CHK({handshake_o, mech_o, pixel_valid_o, idle_state_o}, 8'he0)
        rst_b_i <= 1'b1;
        test_power_up();
        run_job(1'b0, 1, 1'b0, "colour single page");
        run_job(1'b1, 2, 1'b1, "mono two pages with stalls");
        run_job(1'b0, 2, 1'b0, "colour two pages");
        report_and_stop();
    end
endmodule
